// File: rrs_pkg.sv
// constants and types for the reset release sequencer
package rrs_pkg;
  localparam int GP_W = 20;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SAMPLE_TIME_NS = 1500;
  // least time, rounded up to whole clock cycles (60 at 40 MHz)
  localparam int SAMPLE_CYCLES =
    (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
  localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_CYCLES - 1);
  localparam logic [GP_W-1:0] GP_OFF = 20'h00000;
  typedef enum logic [1:0] {
    ST_HOLD   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_RUN    = 2'b10
  } rrs_state_e;
endpackage

// File: rrs_timer_if.sv
// handshake between sequencer and its release timer
`timescale 1ns/1ps
`default_nettype none
interface rrs_timer_if;
  logic start;
  logic abort;
  logic done;
  modport ctrl (output start, output abort, input done);
  modport tmr (input start, input abort, output done);
endinterface
`default_nettype wire

// File: rrs_release_timer.sv
// one-shot timer marking the test point sampling moment
`timescale 1ns/1ps
`default_nettype none
module rrs_release_timer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  rrs_timer_if.tmr tif
);
  import rrs_pkg::*;

  logic busy_r;
  logic done_r;
  logic [CNT_W-1:0] cnt_r;
  logic last_w;

  assign last_w = busy_r && (cnt_r == SAMPLE_LAST);
  assign tif.done = done_r;

  // abort wins so a re-asserted reset never yields a stale done
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= CNT_ZERO;
    end else begin
      done_r <= last_w && !tif.abort;
      if (tif.abort || last_w) begin
        busy_r <= 1'b0;
        cnt_r <= CNT_ZERO;
      end else if (tif.start) begin
        busy_r <= 1'b1;
        cnt_r <= CNT_ZERO;
      end else if (busy_r) begin
        cnt_r <= cnt_r + CNT_ONE;
      end
    end
  end
endmodule // rrs_release_timer
`default_nettype wire

// File: rrs_reset_release_sequencer.sv
// power-on reset pin handling: pin tri-state, forced lows, test sampling
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - start self-configuration on reset pin rising edge
// - flash pins and general pins tri-stated in reset
// - illumination selects and mirror reset driven low
// - test point: tri-state, sample 1.5 us, drive
// - sampled test point becomes test-mode select bit0
// - general pins usable as outputs after release
module rrs_reset_release_sequencer (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic power_on_reset_low_in,
  input wire logic flash_serial_clock_in,
  input wire logic flash_serial_out_in,
  input wire logic flash_select_a_low_in,
  input wire logic flash_select_b_low_in,
  input wire logic flash_drive_in,
  input wire logic [rrs_pkg::GP_W-1:0] general_pins_core_in,
  input wire logic [rrs_pkg::GP_W-1:0] general_pins_core_oe_in,
  input wire logic illum_select_a_in,
  input wire logic illum_select_b_in,
  input wire logic mirror_enable_reset_low_in,
  input wire logic test_point_zero_in,
  input wire logic test_point_core_in,
  output logic flash_serial_clock_out,
  output logic flash_serial_out_out,
  output logic flash_select_a_low_out,
  output logic flash_select_b_low_out,
  output logic flash_oe_out,
  output logic [rrs_pkg::GP_W-1:0] general_pins_out,
  output logic [rrs_pkg::GP_W-1:0] general_pins_oe_out,
  output logic illum_select_a_out,
  output logic illum_select_b_out,
  output logic mirror_enable_reset_low_out,
  output logic test_point_zero_out,
  output logic test_point_zero_oe_out,
  output logic test_mode_select_out,
  output logic config_start_out
);
  import rrs_pkg::*;

  logic rst_s1_r;
  logic rst_s2_r;
  logic rst_n;
  logic por_s1_r;
  logic por_s2_r;
  logic por_d_r;
  logic tp_s1_r;
  logic tp_s2_r;
  rrs_state_e state_r;
  rrs_state_e state_nxt;
  logic por_rise_w;
  logic start_w;
  logic capture_w;
  logic held_w;
  logic run_w;
  logic [GP_W-1:0] gp_oe_w;

  rrs_timer_if tif ();

  // chip reset released through two flops
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      por_s1_r <= 1'b0;
      por_s2_r <= 1'b0;
      por_d_r <= 1'b0;
      tp_s1_r <= 1'b0;
      tp_s2_r <= 1'b0;
    end else begin
      por_s1_r <= power_on_reset_low_in;
      por_s2_r <= por_s1_r;
      por_d_r <= por_s2_r;
      tp_s1_r <= test_point_zero_in;
      tp_s2_r <= tp_s1_r;
    end
  end

  // edge detect on the clean copy only, so each synchronised rise in hold gives one start
  assign por_rise_w = por_s2_r && !por_d_r;
  assign start_w = (state_r == ST_HOLD) && por_rise_w;
  assign capture_w = (state_r == ST_SAMPLE) && tif.done;
  assign tif.start = start_w;
  assign tif.abort = !por_s2_r;

  // sequencing; any return of the reset pin aborts back to hold
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_HOLD: begin
        if (start_w) begin
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (!por_s2_r) begin
          state_nxt = ST_HOLD;
        end else if (tif.done) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!por_s2_r) begin
          state_nxt = ST_HOLD;
        end
      end
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
  end

  // outputs follow the next state so they settle with it
  assign held_w = (state_nxt == ST_HOLD);
  assign run_w = (state_nxt == ST_RUN);
  // unused pins may be set as outputs once released
  assign gp_oe_w = held_w ? GP_OFF : general_pins_core_oe_in;

  rrs_release_timer u_timer (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .tif(tif)
  );

  // state and the registered sampled select bit
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_HOLD;
      config_start_out <= 1'b0;
      test_mode_select_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      config_start_out <= start_w;
      if (capture_w) begin
        test_mode_select_out <= tp_s2_r;
      end
    end
  end

  // flash and general pins: no drive while held
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      flash_oe_out <= 1'b0;
      flash_serial_clock_out <= 1'b0;
      flash_serial_out_out <= 1'b0;
      flash_select_a_low_out <= 1'b0;
      flash_select_b_low_out <= 1'b0;
      general_pins_out <= GP_OFF;
      general_pins_oe_out <= GP_OFF;
    end else begin
      flash_oe_out <= !held_w && flash_drive_in;
      flash_serial_clock_out <= flash_serial_clock_in;
      flash_serial_out_out <= flash_serial_out_in;
      flash_select_a_low_out <= flash_select_a_low_in;
      flash_select_b_low_out <= flash_select_b_low_in;
      general_pins_out <= general_pins_core_in;
      general_pins_oe_out <= gp_oe_w;
    end
  end

  // forced lows in reset; test point drives only after its sample
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      illum_select_a_out <= 1'b0;
      illum_select_b_out <= 1'b0;
      mirror_enable_reset_low_out <= 1'b0;
      test_point_zero_out <= 1'b0;
      test_point_zero_oe_out <= 1'b0;
    end else begin
      illum_select_a_out <= !held_w && illum_select_a_in;
      illum_select_b_out <= !held_w && illum_select_b_in;
      mirror_enable_reset_low_out <= !held_w
        && mirror_enable_reset_low_in;
      test_point_zero_out <= run_w && test_point_core_in;
      test_point_zero_oe_out <= run_w;
    end
  end

  chk_start_on_rise: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    $rose(por_s2_r) |=> config_start_out)
    else $error("no configuration start after reset pin rise");

  chk_sync_delay: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    config_start_out |-> $past(power_on_reset_low_in, 3))
    else $error("configuration start without synchronised pin");

  chk_hold_tristate: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    !por_s2_r |=> !flash_oe_out && (general_pins_oe_out == GP_OFF))
    else $error("flash or general pins driven while held");

  chk_hold_forced_low: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    !por_s2_r |=> !illum_select_a_out && !illum_select_b_out
      && !mirror_enable_reset_low_out)
    else $error("forced low outputs not low while held");

  chk_tp_hold_off: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    !por_s2_r |=> !test_point_zero_oe_out)
    else $error("test point driven while held");

  // timer raises done a sample count after start, then state and drive take one more cycle
  chk_tp_sample_time: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    $rose(test_point_zero_oe_out) |->
      $past(config_start_out, SAMPLE_CYCLES + 1))
    else $error("test point drive not at sample delay after start");

  chk_test_mode_select_capture: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    $rose(test_point_zero_oe_out) |->
      test_mode_select_out == $past(tp_s2_r))
    else $error("select bit differs from sampled test point");

  chk_gp_follow: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n)
    (state_r == ST_RUN) && por_s2_r |=>
      general_pins_oe_out == $past(general_pins_core_oe_in))
    else $error("general pin enables not following core after release");
endmodule // rrs_reset_release_sequencer
`default_nettype wire

// File: rrs_host_model.sv
// host side model: reset pin, fast park line and test point strap
`timescale 1ns/1ps
`default_nettype none
module rrs_host_model (
  input wire logic clk_in,
  input wire logic release_in,
  input wire logic strap_in,
  input wire logic tp_drive_in,
  input wire logic tp_oe_in,
  output logic power_on_reset_low_out,
  output logic fast_park_low_out,
  output logic tp_level_out
);
  // park goes high once the clock runs, long before any release
  initial fast_park_low_out = 1'b0;
  always @(negedge clk_in) begin
    fast_park_low_out <= 1'b1;
  end
  // pin only rises after park is high; no i2c port, so none is issued
  assign power_on_reset_low_out = release_in & fast_park_low_out;
  // weak pulldown unless the strap models an external pullup
  assign tp_level_out = tp_oe_in ? tp_drive_in : strap_in;
endmodule // rrs_host_model
`default_nettype wire

// File: rrs_reset_release_sequencer_tb.sv
// self-checking bench for the reset release sequencer
`timescale 1ns/1ps
`default_nettype none
module rrs_reset_release_sequencer_tb;
  import rrs_pkg::*;
  typedef struct packed {logic [47:0] inp; logic [47:0] exp;} rrs_row_s;
  // while held enables and forced lows drop; all flash and general pin data keeps following core
  localparam logic [47:0] HELD_KEEP = 48'hf7ffff800000;
  logic sys_clk, rst_n, rel, strap, tp_core;
  logic [47:0] core_v;
  wire [47:0] obs;
  wire tp_lvl, por_n, park_n, tp_out, tp_oe, tms, cfg;
  int fails, samples_checked;
  rrs_row_s rows [4];
  rrs_host_model u_host (.clk_in(sys_clk), .release_in(rel),
    .strap_in(strap), .tp_drive_in(tp_out), .tp_oe_in(tp_oe),
    .power_on_reset_low_out(por_n), .fast_park_low_out(park_n),
    .tp_level_out(tp_lvl));
  rrs_reset_release_sequencer u_dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .power_on_reset_low_in(por_n), .flash_serial_clock_in(core_v[47]),
    .flash_serial_out_in(core_v[46]), .flash_select_a_low_in(core_v[45]),
    .flash_select_b_low_in(core_v[44]), .flash_drive_in(core_v[43]),
    .general_pins_core_in(core_v[42:23]),
    .general_pins_core_oe_in(core_v[22:3]), .illum_select_a_in(core_v[2]),
    .illum_select_b_in(core_v[1]), .mirror_enable_reset_low_in(core_v[0]),
    .test_point_zero_in(tp_lvl), .test_point_core_in(tp_core),
    .flash_serial_clock_out(obs[47]), .flash_serial_out_out(obs[46]),
    .flash_select_a_low_out(obs[45]), .flash_select_b_low_out(obs[44]),
    .flash_oe_out(obs[43]), .general_pins_out(obs[42:23]),
    .general_pins_oe_out(obs[22:3]), .illum_select_a_out(obs[2]),
    .illum_select_b_out(obs[1]), .mirror_enable_reset_low_out(obs[0]),
    .test_point_zero_out(tp_out), .test_point_zero_oe_out(tp_oe),
    .test_mode_select_out(tms), .config_start_out(cfg));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // bounded wait on start pulse (sel 0) or test point drive (sel 1)
  task automatic wait_hi(input int sel, output int k);
    k = 0;
    while ((sel ? tp_oe : cfg) !== 1'b1 && k < 200) begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 200) begin
      fails++;
      test_done();
    end
  endtask
  // raise the pin, time the start pulse and the sampling moment
  task automatic start(input logic s);
    int k;
    strap = s;
    rel = 1'b1;
    wait_hi(0, k);
    chk(48'(k), 48'h3);
    @(negedge sys_clk);
    chk(48'(cfg), 48'h0);
    wait_hi(1, k);
    chk(48'(k), 48'(SAMPLE_CYCLES));
    chk(48'(tms), 48'(s));
  endtask
  initial begin
    rst_n = 1'b0;
    rel = 1'b0;
    strap = 1'b0;
    tp_core = 1'b0;
    core_v = '1;
    fails = 0;
    samples_checked = 0;
    rows[0] = {48'hffffffffffff, 48'hffffffffffff};
    rows[1] = {48'h000000000000, 48'h000000000000};
    rows[2] = {48'haaaaaaaaaaaa, 48'haaaaaaaaaaaa};
    rows[3] = {48'h555555555555, 48'h555555555555};
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    // core asks for everything, pin still held low
    chk(obs, core_v & HELD_KEEP);
    chk(48'(tp_oe), 48'h0);
    $display("hold test done");
    start(1'b1);
    tp_core = 1'b1;
    @(negedge sys_clk);
    chk(48'(tp_out), 48'h1);
    $display("strap high test done");
    foreach (rows[i]) begin
      core_v = rows[i].inp;
      @(negedge sys_clk);
      chk(obs, rows[i].exp);
    end
    $display("pass through test done");
    // reassert: pins float again, select keeps its last sample
    rel = 1'b0;
    core_v = '1;
    repeat (4) @(negedge sys_clk);
    chk(obs, core_v & HELD_KEEP);
    chk(48'(tp_oe), 48'h0);
    chk(48'(tms), 48'h1);
    // drop the pin mid-sampling: no sample, no drive
    strap = 1'b0;
    rel = 1'b1;
    repeat (20) @(negedge sys_clk);
    rel = 1'b0;
    repeat (70) @(negedge sys_clk);
    chk(48'(tp_oe), 48'h0);
    chk(48'(tms), 48'h1);
    $display("abort test done");
    start(1'b0);
    $display("strap low test done");
    test_done();
  end
endmodule // rrs_reset_release_sequencer_tb
`default_nettype wire
